//--- include/remedy_event_pkg.sv
// remedy event flag register constants and carrier types
// assumes a single clock domain and an 8-bit register access port
`default_nettype none

package remedy_event_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] event_flags_offset = 8'h15;
	localparam logic [7:0] event_mask_offset = 8'h0f;
	localparam logic [7:0] event_flags_reset = 8'h00;
	localparam logic [7:0] event_mask_reset = 8'h00;
	localparam logic [7:0] implemented_bits = 8'h6f;

	// ****************************************
	// field positions
	// ****************************************
	localparam int remedy_started_bit = 0;
	localparam int forced_role_done_bit = 1;
	localparam int forced_role_failed_bit = 2;
	localparam int remedy_failed_bit = 3;
	localparam int remedy_vbus_on_bit = 5;
	localparam int remedy_vbus_off_bit = 6;
	localparam int event_count = 8;

	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// internal event sources, one pulse each
	typedef struct packed {
		logic remedy_vbus_off;
		logic remedy_vbus_on;
		logic remedy_failed;
		logic forced_role_failed;
		logic forced_role_done;
		logic remedy_started;
	} event_src_s;

endpackage : remedy_event_pkg

`default_nettype wire

//--- logic/event_flag_bit.sv
// one sticky write-one-to-clear flag with mask gating
// assumes synchronous active-low reset and a clock enable
`default_nettype none

module event_flag_bit
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// control
	input wire logic set,
	input wire logic clear,
	input wire logic mask,
	// state
	output logic flag,
	output logic pending
);

	// set beats clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!resetn)
			flag <= 1'b0;
		else if (ce)
		begin
			if (set)
				flag <= 1'b1;
			else if (clear)
				flag <= 1'b0;
		end
	end

	// mask only hides the flag from the pin
	assign pending = flag & ~mask;

endmodule : event_flag_bit

`default_nettype wire

//--- logic/attach_remedy_event_flags.sv
// event flag and mask registers of the attach remedy logic
// assumes register port requests synchronous to clk, one per cycle
// assumes event sources give one-cycle pulses on clk
// assumes the host clears flags by writing ones
`default_nettype none

module attach_remedy_event_flags
#(
	parameter int width = 8
)
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	// register access port
	input wire remedy_event_pkg::reg_req_s req,
	output logic [width-1:0] rdata,
	// event sources
	input wire remedy_event_pkg::event_src_s events,
	input wire logic remedy_active,
	// interrupt pin
	output logic int_n
);

	// ****************************************
	// local constants
	// ****************************************
	// register-wide copies of the package maps
	localparam logic [width-1:0] impl_bits = remedy_event_pkg::implemented_bits[width-1:0];
	localparam logic [width-1:0] mask_reset = remedy_event_pkg::event_mask_reset[width-1:0];

	// ****************************************
	// register decode
	// ****************************************
	// register selects and qualified strobes
	logic flags_hit;
	logic mask_hit;
	logic flags_wr;
	logic mask_wr;
	logic rd_take;

	// address match for the two mapped registers
	assign flags_hit = (req.addr == remedy_event_pkg::event_flags_offset);
	assign mask_hit = (req.addr == remedy_event_pkg::event_mask_offset);

	// writes and reads only count on enabled edges
	assign flags_wr = ce & req.wr & flags_hit;
	assign mask_wr = ce & req.wr & mask_hit;
	assign rd_take = ce & req.rd;

	// ****************************************
	// event qualification
	// ****************************************
	// gated vbus requests
	logic vbus_off_req;
	logic vbus_on_req;

	// vbus requests only count while the remedy runs
	assign vbus_off_req = events.remedy_vbus_off & remedy_active;
	assign vbus_on_req = events.remedy_vbus_on & remedy_active;

	// ****************************************
	// event set map
	// ****************************************
	// per-bit set strobes
	logic [width-1:0] set_vec;

	// place each event on its bit, reserved bits never set
	always_comb
	begin
		set_vec = '0;
		// remedy progress and vbus requests
		set_vec[remedy_event_pkg::remedy_vbus_off_bit] = vbus_off_req;
		set_vec[remedy_event_pkg::remedy_vbus_on_bit] = vbus_on_req;
		set_vec[remedy_event_pkg::remedy_failed_bit] = events.remedy_failed;
		set_vec[remedy_event_pkg::remedy_started_bit] = events.remedy_started;
		// forced role outcomes
		set_vec[remedy_event_pkg::forced_role_failed_bit] = events.forced_role_failed;
		set_vec[remedy_event_pkg::forced_role_done_bit] = events.forced_role_done;
	end

	// ****************************************
	// clear map
	// ****************************************
	// per-bit clear strobes
	logic [width-1:0] clear_vec;

	// ones clear their flag, zeros leave it alone
	always_comb
	begin
		clear_vec = '0;
		if (flags_wr)
		begin
			clear_vec = req.wdata[width-1:0] & impl_bits;
		end
	end

	// ****************************************
	// flag storage
	// ****************************************
	// flag, pending and mask vectors
	logic [width-1:0] flags;
	logic [width-1:0] pending;
	logic [width-1:0] mask_reg;

	// one sticky cell per implemented bit
	genvar i;
	generate
		for (i = 0; i < width; i++)
		begin : g_flag
			if (impl_bits[i])
			begin : g_impl
				// sticky cell, set wins over clear
				event_flag_bit u_bit
				(
					.clk(clk),
					.resetn(resetn),
					.ce(ce),
					.set(set_vec[i]),
					.clear(clear_vec[i]),
					.mask(mask_reg[i]),
					.flag(flags[i]),
					.pending(pending[i])
				);
			end
			else
			begin : g_rsvd
				// reserved bits read zero and never pend
				assign flags[i] = 1'b0;
				assign pending[i] = 1'b0;
			end
		end
	endgenerate

	// ****************************************
	// mask register
	// ****************************************
	// mask writes keep reserved bits at zero
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			mask_reg <= mask_reset;
		end
		else if (mask_wr)
		begin
			mask_reg <= req.wdata[width-1:0] & impl_bits;
		end
	end

	// ****************************************
	// read data
	// ****************************************
	// read mux output
	logic [width-1:0] read_value;

	// read mux, unmapped addresses give zero
	always_comb
	begin
		read_value = '0;
		if (flags_hit)
		begin
			read_value = flags;
		end
		else if (mask_hit)
		begin
			read_value = mask_reg;
		end
	end

	// read data registered and held until the next read
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rdata <= '0;
		end
		else if (rd_take)
		begin
			rdata <= read_value;
		end
	end

	// ****************************************
	// pending summary
	// ****************************************
	// any unmasked flag
	logic any_pending;

	// one unmasked flag is enough to pull the pin
	assign any_pending = |pending;

	// ****************************************
	// interrupt pin
	// ****************************************
	// pin follows pending one enabled edge later
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			int_n <= 1'b1;
		end
		else if (ce)
		begin
			int_n <= ~any_pending;
		end
	end

endmodule : attach_remedy_event_flags

`default_nettype wire

//--- sim/remedy_event_properties.sv
// port checker for the event flag register
// assumes bind to the top module
`default_nettype none
module remedy_event_properties
(
	// design ports
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire remedy_event_pkg::reg_req_s req,
	input wire logic [7:0] rdata,
	input wire remedy_event_pkg::event_src_s events,
	input wire logic remedy_active,
	input wire logic int_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] m;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// shadow of the mask register
	always_ff @(posedge clk)
		if (!resetn)
			m <= 8'h00;
		else if (ce && req.wr && req.addr == remedy_event_pkg::event_mask_offset)
			m <= req.wdata & remedy_event_pkg::implemented_bits;
	// unmasked event pulls the pin low two cycles on
	property p_ev(e, b);
		ce && e ##1 ce && !b |=> !int_n;
	endproperty
	AST_RSVD: assert property (!rdata[7] && !rdata[4]) else $error("reserved");
	AST_START: assert property (p_ev(events.remedy_started, m[0])) else $error("start");
	AST_DONE: assert property (p_ev(events.forced_role_done, m[1])) else $error("done");
	AST_FFAIL: assert property (p_ev(events.forced_role_failed, m[2])) else $error("ffail");
	AST_RFAIL: assert property (p_ev(events.remedy_failed, m[3])) else $error("rfail");
	AST_VON: assert property (p_ev(remedy_active && events.remedy_vbus_on, m[5])) else $error("von");
	AST_VOFF: assert property (p_ev(remedy_active && events.remedy_vbus_off, m[6])) else $error("voff");
	AST_MASK: assert property (ce && m == remedy_event_pkg::implemented_bits |=> int_n) else $error("mask");
	cover property (!int_n);
	cover property (req.wr);
	cover property (req.rd);
endmodule : remedy_event_properties
bind attach_remedy_event_flags remedy_event_properties u_props (.clk(clk), .resetn(resetn), .ce(ce),
	.req(req), .rdata(rdata), .events(events), .remedy_active(remedy_active), .int_n(int_n));
`default_nettype wire

//--- sim/remedy_host_model.sv
// host register access model
// assumes callers start on a falling edge
`default_nettype none
module remedy_host_model
(
	// clock and request
	input wire logic clk,
	output var remedy_event_pkg::reg_req_s req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;
	// one-cycle strobe held over the rising edge, then one idle edge
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
		req = '{w, !w, a, d};
		@(negedge clk);
		req = '0;
		@(negedge clk);
	endtask : access
endmodule : remedy_host_model
`default_nettype wire

//--- sim/attach_remedy_event_flags_test.sv
// bench for the event flag register
// assumes the host model makes every access
`default_nettype none
module attach_remedy_event_flags_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, ce, remedy_active, int_n;
	logic [7:0] rdata;
	remedy_event_pkg::reg_req_s req;
	remedy_event_pkg::event_src_s events;
	int fail_count, tests_run;
	remedy_host_model u_remedy_host_model (.clk(clk), .req(req));
	attach_remedy_event_flags u_attach_remedy_event_flags (.clk(clk), .resetn(resetn), .ce(ce), .req(req),
		.rdata(rdata), .events(events), .remedy_active(remedy_active), .int_n(int_n));
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask : check
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		u_remedy_host_model.access(1'h0, a, 8'h00);
		check("rdata", rdata, e);
	endtask : rd
	task automatic pulse(input remedy_event_pkg::event_src_s e);
		events = e;
		@(negedge clk);
		events = '0;
		repeat (2) @(negedge clk);
	endtask : pulse
	task automatic test_set_clear;
		remedy_active = 1'h1;
		pulse(6'h3f);
		rd(8'h15, 8'h6f);
		check("int_n", int_n, 8'h00);
		u_remedy_host_model.access(1'h1, 8'h15, 8'h05);
		rd(8'h15, 8'h6a);
		u_remedy_host_model.access(1'h1, 8'h15, 8'hff);
		rd(8'h15, 8'h00);
		@(negedge clk);
		check("int_n", int_n, 8'h01);
	endtask : test_set_clear
	task automatic test_mask;
		u_remedy_host_model.access(1'h1, 8'h0f, 8'hff);
		rd(8'h0f, 8'h6f);
		pulse(6'h01);
		rd(8'h15, 8'h01);
		check("int_n", int_n, 8'h01);
		rd(8'h33, 8'h00);
		u_remedy_host_model.access(1'h1, 8'h0f, 8'h00);
		check("int_n", int_n, 8'h00);
	endtask : test_mask
	task automatic test_vbus_gate;
		remedy_active = 1'h0;
		pulse(6'h30);
		rd(8'h15, 8'h00);
		check("int_n", int_n, 8'h01);
		remedy_active = 1'h1;
	endtask : test_vbus_gate
	task automatic test_set_beats_clear;
		fork
			pulse(6'h02);
			u_remedy_host_model.access(1'h1, 8'h15, 8'h02);
		join
		rd(8'h15, 8'h02);
		check("int_n", int_n, 8'h00);
		u_remedy_host_model.access(1'h1, 8'h15, 8'h02);
		rd(8'h15, 8'h00);
		check("int_n", int_n, 8'h01);
	endtask : test_set_beats_clear
	task automatic test_freeze;
		ce = 1'h0;
		pulse(6'h01);
		ce = 1'h1;
		rd(8'h15, 8'h00);
		check("int_n", int_n, 8'h01);
	endtask : test_freeze
	task automatic tally_and_finish;
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	// free-running clock
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// reset, then the scenarios
	initial
	begin
		{resetn, ce, remedy_active, events} = 9'h080;
		fail_count = 0;
		tests_run = 0;
		repeat (16) @(negedge clk);
		resetn = 1'h1;
		rd(8'h15, 8'h00);
		test_set_clear();
		test_vbus_gate();
		test_set_beats_clear();
		test_freeze();
		test_mask();
		tally_and_finish();
	end
	// hang guard
	initial
	begin
		#5000;
		fail_count++;
		tally_and_finish();
	end
endmodule : attach_remedy_event_flags_test
`default_nettype wire
